// ### mrs_host.sv
`timescale 1ns/1ps
// host controller: drives strobe and shift clock, captures all eight channels
module mrs_host (
  input wire logic REF_CLK, // 40 MHz reference
  input wire logic RST_B, // async reset, active low
  input wire logic START, // one-cycle request for a conversion
  input wire logic [1:0] LANE_MODE, // 0:8 lanes 1:4 2:2 3:1 (diff: 0/1/2 map to 4,2,1)
  input wire logic DIFF_MODE, // 1 = differential pairs
  input wire logic RATE_SELECT, // 1 = double rate, mirror of board strap
  input wire logic [7:0] SERIAL_RESULT_LANE, // lane pins (diff pairs A..D on bits 0..3)
  output logic CONVERT_STROBE, // conversion strobe to device
  output logic SHIFT_CLK, // serial clock to device
  output logic BUSY, // conversion in progress
  output logic DATA_VALID, // one-cycle pulse, results ready
  output logic [mrs_pkg::NUM_CH*mrs_pkg::RES_BITS-1:0] RESULTS // channel 1 in low word
);
  // sequence of one conversion, all counts in reference cycles:
  //   idle: a start request latches lane mode, pair mode and rate
  //   strobe: convert strobe high for the sampling time
  //   conv: strobe low, wait the worst conversion time, shift clock held low
  //   shift: shift clock toggles every half period, one lane bit taken per data edge
  //   done: words are picked per channel by position and shown with a valid pulse
  // lane pins reach the capture registers three cycles after they move (pin, two
  // synchroniser stages), so the half period must stay above that latency; the
  // bit is taken on the reference edge that launches the next shift clock change,
  // when the previous bit has settled through the synchroniser.
  // single rate: the device moves data on the falling edge, so bits are taken
  // just before each rise; double rate: data moves on every edge, so a bit is
  // taken before each toggle.
  // every lane pin is shifted for the full per-lane bit count, also in modes where
  // some pins carry nothing of use; words of unused pins are simply not selected.
  // limitation: the returned clock is not used, so the shift clock rate is
  // bounded by the synchroniser latency rather than by the link itself.
  localparam int SW = mrs_pkg::NUM_CH * mrs_pkg::RES_BITS; // stream width
  mrs_pkg::mrs_state_t state_r; // sequencer state
  logic [9:0] cnt_r; // wait and half-period counter
  logic [8:0] edges_r; // edges left to supply; 256 in single rate over one lane
  logic [1:0] mode_r; // latched lane mode
  logic diff_r; // latched diff mode
  logic ddr_r; // latched rate
  logic clear_s; // deserializer clear
  logic sample_s; // deserializer capture
  logic [mrs_pkg::SE_BITS_TOTAL-1:0] lane_bits [mrs_pkg::NUM_LANES]; // per-lane streams, up to 128 bits
  logic [SW-1:0] words_s; // channel words picked by position, channel 1 low
  logic [3:0] lanes_used; // active lane count
  logic [7:0] edges_need; // bits per lane per conversion; edges at double rate, half the edges at single rate
  // active lane count from mode; diff mode uses pairs 4/2/1
  always_comb begin
    unique case (mode_r)
      mrs_pkg::MODE_L8: lanes_used = diff_r ? 4'h4 : 4'h8;
      mrs_pkg::MODE_L4: lanes_used = diff_r ? 4'h2 : 4'h4;
      mrs_pkg::MODE_L2: lanes_used = diff_r ? 4'h1 : 4'h2;
      mrs_pkg::MODE_L1: lanes_used = 4'h1;
    endcase
  end
  // bits per lane are 128 over the lane or pair count in both pin modes; a pair
  // carries two channels per 32 bits, so the same total covers all eight channels
  always_comb begin
    edges_need = 8'(mrs_pkg::SE_BITS_TOTAL / int'(lanes_used));
  end
  // main sequencer
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= mrs_pkg::ST_IDLE;
      cnt_r <= '0;
      edges_r <= '0;
      mode_r <= mrs_pkg::MODE_L8;
      diff_r <= 1'b0;
      ddr_r <= 1'b0;
      CONVERT_STROBE <= 1'b0;
      SHIFT_CLK <= 1'b0;
    end else begin
      unique case (state_r)
        mrs_pkg::ST_IDLE: begin
          if (START) begin
            mode_r <= LANE_MODE; // no device reconfiguration needed
            diff_r <= DIFF_MODE;
            ddr_r <= RATE_SELECT; // follows the strap
            CONVERT_STROBE <= 1'b1; // sample
            cnt_r <= 10'(mrs_pkg::STROBE_CYC);
            state_r <= mrs_pkg::ST_STROBE;
          end
        end
        mrs_pkg::ST_STROBE: begin
          if (cnt_r <= 10'h001) begin
            CONVERT_STROBE <= 1'b0; // start conversion
            cnt_r <= 10'(mrs_pkg::CONV_CYC); // wait worst conversion
            state_r <= mrs_pkg::ST_CONV;
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        mrs_pkg::ST_CONV: begin
          if (cnt_r <= 10'h001) begin
            cnt_r <= 10'(mrs_pkg::SCK_HALF_CYC);
            // sdr needs rise and fall per bit, ddr one edge per bit
            edges_r <= ddr_r ? {1'b0, edges_need} : {edges_need, 1'b0};
            state_r <= mrs_pkg::ST_SHIFT;
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        mrs_pkg::ST_SHIFT: begin
          if (cnt_r <= 10'h001) begin
            cnt_r <= 10'(mrs_pkg::SCK_HALF_CYC);
            if (edges_r == 9'h000) begin
              SHIFT_CLK <= 1'b0;
              state_r <= mrs_pkg::ST_DONE; // longer readout with fewer lanes
            end else begin
              SHIFT_CLK <= ~SHIFT_CLK;
              edges_r <= edges_r - 9'h001;
            end
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        mrs_pkg::ST_DONE: begin
          state_r <= mrs_pkg::ST_IDLE;
        end
        default: state_r <= mrs_pkg::ST_IDLE;
      endcase
    end
  end
  // sample just before the next clock change; data was shifted at the previous edge.
  // in sdr data moves on falling edges, so sample only before the rise.
  always_comb begin
    clear_s = (state_r == mrs_pkg::ST_CONV);
    sample_s = (state_r == mrs_pkg::ST_SHIFT) && (cnt_r == 10'h001) && (edges_r != 9'h000)
               && (ddr_r || !SHIFT_CLK);
  end
  // one deserializer per lane pin
  genvar g;
  generate
    for (g = 0; g < mrs_pkg::NUM_LANES; g++) begin : g_lane
      mrs_lane_deser u_deser (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .lane_in(SERIAL_RESULT_LANE[g]),
        .clear(clear_s),
        .sample(sample_s),
        .bits_out(lane_bits[g])
      );
    end
  endgenerate
  // pick each channel by position: word k of a used lane is channel start(lane)+k
  generate
    for (g = 0; g < mrs_pkg::NUM_CH; g++) begin : g_chan
      int per_s; // results taken per used lane
      int ln_s; // pin index of the lane that holds this channel
      int wd_s; // word position within that lane's stream
      int nb_s; // bits shifted per lane in this mode
      // used single-ended lanes sit at pins 0,2,4,6 or 0,4; used pairs at 0,1,2,3 or 0,2
      always_comb begin
        per_s = mrs_pkg::NUM_CH / int'(lanes_used);
        ln_s = (g / per_s) * ((diff_r ? mrs_pkg::NUM_CH / 2 : mrs_pkg::NUM_CH) / int'(lanes_used));
        wd_s = g % per_s;
        nb_s = mrs_pkg::SE_BITS_TOTAL / int'(lanes_used);
      end
      // stream holds nb bits ending at lsb; word wd starts at bit nb-1-wd*RES_BITS
      assign words_s[g*mrs_pkg::RES_BITS +: mrs_pkg::RES_BITS] =
        lane_bits[ln_s][(nb_s - (wd_s + 1) * mrs_pkg::RES_BITS) +: mrs_pkg::RES_BITS];
    end
  endgenerate
  // outputs; results move only with the valid pulse so a reader may take them late
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RESULTS <= '0;
      DATA_VALID <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      BUSY <= (state_r != mrs_pkg::ST_IDLE) || START;
      DATA_VALID <= (state_r == mrs_pkg::ST_DONE);
      // capture once the last bit has been taken
      if (state_r == mrs_pkg::ST_DONE) begin
        RESULTS <= words_s;
      end
    end
  end
  // returned clock is not used: data sampled from own clock timing
endmodule

// ### mrs_pkg.sv
// package of constants for the multilane result serializer host receiver
package mrs_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RES_BITS = 14;
  localparam int NUM_CH = 8;
  localparam int NUM_LANES = 8;
  localparam int SE_BITS_TOTAL = 128;
  localparam int DDR_BITS_TOTAL = 64;
  // strobe high time and worst conversion time
  localparam int T_STROBE_NS = 30;
  localparam int T_CONV_NS = 500;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // serial clock half period in reference cycles; it must exceed the three-cycle
  // lane latency (pin change, two synchroniser stages), which gives a 200 ns shift clock
  localparam int SCK_HALF_CYC = 4;
  localparam logic [1:0] MODE_L8 = 2'h0;
  localparam logic [1:0] MODE_L4 = 2'h1;
  localparam logic [1:0] MODE_L2 = 2'h2;
  localparam logic [1:0] MODE_L1 = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_STROBE = 3'h1,
    ST_CONV = 3'h2,
    ST_SHIFT = 3'h3,
    ST_DONE = 3'h4
  } mrs_state_t;
endpackage

// ### mrs_lane_deser.sv
`timescale 1ns/1ps
// one-lane deserializer with two-flop synchroniser
module mrs_lane_deser (
  input wire logic clk, // reference clock
  input wire logic rst_b, // async reset, active low
  input wire logic lane_in, // raw lane pin
  input wire logic clear, // start of readout
  input wire logic sample, // capture one bit
  output logic [mrs_pkg::SE_BITS_TOTAL-1:0] bits_out // stream, last bit at lsb; first bit at top only once all 128 bits are in
);
  logic meta_r; // first stage, read only by sync_r
  logic sync_r; // second stage
  // synchroniser; lag is covered by sampling late in the clock period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= lane_in;
      sync_r <= meta_r;
    end
  end
  // shift left so first bit (an MSB) ends up at the top once full
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bits_out <= '0;
    end else if (clear) begin
      bits_out <= '0;
    end else if (sample) begin
      bits_out <= {bits_out[mrs_pkg::SE_BITS_TOTAL-2:0], sync_r};
    end
  end
endmodule

// ### mrs_host_asserts.sv
// port checks for the host receiver
`timescale 1ns/1ps
module mrs_host_asserts (
  input wire logic REF_CLK, // reference clock
  input wire logic RST_B, // reset, active low
  input wire logic START, // request
  input wire logic [1:0] LANE_MODE, // lane count
  input wire logic DIFF_MODE, // pairs
  input wire logic RATE_SELECT, // double rate
  input wire logic [7:0] SERIAL_RESULT_LANE, // lanes
  input wire logic CONVERT_STROBE, // strobe
  input wire logic SHIFT_CLK, // shift clock
  input wire logic BUSY, // busy
  input wire logic DATA_VALID, // done pulse
  input wire logic [111:0] RESULTS // results
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // strobe stays up two cycles
  sequence s_strobe; CONVERT_STROBE [*2] ##1 !CONVERT_STROBE; endsequence
  // no shifting in the first eight cycles after the strobe falls
  sequence s_quiet; !SHIFT_CLK [*8]; endsequence
  // shift clock high for one half period of four reference cycles
  sequence s_sck_high; SHIFT_CLK [*4] ##1 !SHIFT_CLK; endsequence
  // cycles spent busy; a one-lane single-rate readout is the longest case
  logic [11:0] busy_cnt_r;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_cnt_r <= '0;
    end else if (!BUSY) begin
      busy_cnt_r <= '0;
    end else if (busy_cnt_r != 12'hFFF) begin
      busy_cnt_r <= busy_cnt_r + 12'h001;
    end
  end
  a_start_taken: assert property (START && !BUSY && !DATA_VALID |=> CONVERT_STROBE && BUSY)
    else $error("start not taken");
  a_strobe_pulse: assert property ($rose(CONVERT_STROBE) |-> s_strobe)
    else $error("strobe width wrong");
  a_conv_quiet: assert property ($fell(CONVERT_STROBE) |-> s_quiet)
    else $error("clock during conversion");
  a_valid_bound: assert property (busy_cnt_r <= 12'h44C)
    else $error("readout too long");
  a_valid_once: assert property (DATA_VALID |=> !DATA_VALID)
    else $error("valid too long");
  a_idle_clk: assert property (!BUSY |-> !SHIFT_CLK)
    else $error("clock runs idle");
  a_results_hold: assert property (!DATA_VALID |-> $stable(RESULTS))
    else $error("results moved");
  a_sck_half: assert property ($rose(SHIFT_CLK) |-> s_sck_high)
    else $error("clock half period wrong");
  a_strobe_busy: assert property (CONVERT_STROBE |-> BUSY)
    else $error("strobe while idle");
endmodule
bind mrs_host mrs_host_asserts mrs_host_asserts_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .START(START),
  .LANE_MODE(LANE_MODE), .DIFF_MODE(DIFF_MODE), .RATE_SELECT(RATE_SELECT), .SERIAL_RESULT_LANE(SERIAL_RESULT_LANE),
  .CONVERT_STROBE(CONVERT_STROBE), .SHIFT_CLK(SHIFT_CLK), .BUSY(BUSY), .DATA_VALID(DATA_VALID), .RESULTS(RESULTS));

// ### mrs_adc_model.sv
// behavioural converter streaming results on every lane
`timescale 1ns/1ps
module mrs_adc_model (
  input wire logic strobe, // conversion strobe
  input wire logic sck, // shift clock
  input wire logic ddr, // double rate strap
  input wire logic diff, // pair mode
  input wire logic [111:0] data, // channel ch at ch*14
  output logic [7:0] lane // lane pins
);
  int k = 0; // bits shifted since readout start
  // readout restarts when the strobe falls
  always @(negedge strobe) k = 0;
  // falling edge only, or every edge at double rate
  always @(sck) if (!strobe && (ddr || !sck)) k = k + 1;
  // no returned clock here: the host times capture from its own shift clock
  // circular order from the lane's own channel, msb first
  always @* for (int n = 0; n < 8; n++) lane[n] = data[(((diff ? 2 * n : n) + k / 14) % 8) * 14 + 13 - k % 14];
endmodule

// ### tb_mrs_host.sv
// self-checking bench for the host receiver
`timescale 1ns/1ps
module tb_mrs_host;
  logic REF_CLK, RST_B, START, DIFF_MODE, RATE_SELECT, CONVERT_STROBE, SHIFT_CLK, BUSY, DATA_VALID;
  logic [1:0] LANE_MODE; // lane count
  logic [7:0] SERIAL_RESULT_LANE; // lane pins
  logic [111:0] RESULTS, adc_data; // results, converter data
  logic [111:0] exp_q[$]; // expected results
  logic [31:0] seed = 32'h000066DF; // xorshift state
  int fails = 0;
  int n_tests = 0;
  mrs_host mrs_host_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .START(START), .LANE_MODE(LANE_MODE),
    .DIFF_MODE(DIFF_MODE), .RATE_SELECT(RATE_SELECT), .SERIAL_RESULT_LANE(SERIAL_RESULT_LANE),
    .CONVERT_STROBE(CONVERT_STROBE), .SHIFT_CLK(SHIFT_CLK), .BUSY(BUSY), .DATA_VALID(DATA_VALID), .RESULTS(RESULTS));
  mrs_adc_model mrs_adc_model_i (.strobe(CONVERT_STROBE), .sck(SHIFT_CLK), .ddr(RATE_SELECT),
    .diff(DIFF_MODE), .data(adc_data), .lane(SERIAL_RESULT_LANE));
  // 40 MHz reference
  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic check_res(input logic [111:0] e, input logic [111:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected RESULTS expected %h seen %h", e, g);
    end
  endtask
  task automatic end_of_test;
    fails += exp_q.size();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one conversion with random data; a second start while busy must be ignored
  task automatic run(input logic d, input logic [1:0] m, input logic r);
    logic [127:0] t;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      t = {t[95:0], seed};
    end
    @(posedge REF_CLK);
    DIFF_MODE <= d;
    LANE_MODE <= m;
    RATE_SELECT <= r;
    adc_data <= t[111:0];
    START <= 1'b1;
    exp_q.push_back(t[111:0]);
    @(posedge REF_CLK);
    START <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    START <= 1'b1; // refused while busy
    @(posedge REF_CLK);
    START <= 1'b0;
    for (int i = 0; i < 2000 && DATA_VALID !== 1'b1; i++) @(posedge REF_CLK);
    if (DATA_VALID !== 1'b1) fails++;
    repeat (3) @(posedge REF_CLK);
    $display("test diff %0d mode %0d rate %0d done", d, m, r);
  endtask
  // monitor takes the oldest note at each valid pulse; an empty queue means an extra result
  always @(posedge REF_CLK) if (DATA_VALID === 1'b1) begin
    if (exp_q.size() == 0) check_res('x, RESULTS);
    else check_res(exp_q.pop_front(), RESULTS);
  end
  // main sequence
  initial begin
    RST_B = 1'b0;
    START = 1'b0;
    DIFF_MODE = 1'b0;
    LANE_MODE = 2'h0;
    RATE_SELECT = 1'b0;
    adc_data = '0;
    repeat (6) @(posedge REF_CLK);
    RST_B <= 1'b1;
    for (int r = 0; r < 2; r++) for (int m = 0; m < 4; m++) run(1'b0, m[1:0], r[0]);
    for (int r = 0; r < 2; r++) for (int m = 0; m < 3; m++) run(1'b1, m[1:0], r[0]);
    end_of_test;
  end
  // watchdog well beyond fourteen readouts
  initial begin
    #500000;
    fails++;
    end_of_test;
  end
endmodule
